// file: logic/lpb_ctrl.v
// low-power timer, snapshot capture, brownout handler and power modes
// assumes an apb master on CLK_SYS, slow clock and analog levels as pins
`timescale 1ns/1ns
`default_nettype none
`include "lpb_consts.vh"

module lpb_ctrl #(
    parameter BOD_CNT_W = 16,
    parameter STALL_WAIT = `LPB_STALL_WAIT_CYC
)(
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire LP_SLOW_CLK,
    input wire BROWNOUT_DET,
    input wire CHIP_EN,
    input wire CPU_STALL,
    input wire SYS_RST_DONE,
    input wire WAKE_REQ,
    input wire FIB_DIRECT_RST_EN,
    output reg BROWNOUT_IRQ,
    output reg RADIO_SHUTDOWN,
    output reg CHIP_RESET_REQ,
    output reg SYS_RESET_REQ,
    output reg TIMER_WAKEUP,
    output reg PD_RF_ON,
    output reg PD_FOSC_ON,
    output reg PD_XTAL_ON,
    output reg PD_PLL_ON,
    output reg PD_DIG_ON,
    output reg DIG_REG_PU,
    output reg LP_REG_ON,
    output reg LP_REG_DEEP,
    output reg [1:0] POWER_MODE
);

localparam [1:0] ST_ACTIVE = `LPB_MODE_ACTIVE;
localparam [1:0] ST_MODEM = `LPB_MODE_MODEM;
localparam [1:0] ST_LIGHT = `LPB_MODE_LIGHT;
localparam [1:0] ST_DEEP = `LPB_MODE_DEEP;
localparam [31:0] STALL_W32 = STALL_WAIT;
localparam [15:0] STALL_LIM = STALL_W32[15:0];

function is_sleep;
    input [1:0] m;
    begin
        is_sleep = (m == ST_LIGHT) || (m == ST_DEEP);
    end
endfunction

// synchronisers for pin levels
reg slow_s1, slow_s2, slow_s3;
reg bod_s1, bod_s2;
reg cen_s1, cen_s2;

// state
reg [47:0] timer;
reg [47:0] snap_cur;
reg [47:0] snap_prev;
reg [47:0] alarm;
reg [`LPB_CTRL_W-1:0] ctrl;
reg [`LPB_BOD_W-1:0] bod_ctrl;
reg [BOD_CNT_W-1:0] bod_irq_wait;
reg [BOD_CNT_W-1:0] bod_rst_wait;
reg [BOD_CNT_W-1:0] bod_cnt;
reg [1:0] mode;
reg [1:0] target;
reg [15:0] stall_cnt;
reg stall_d;
reg xtal_d;
reg sw_snap;

wire acc = PSEL & PENABLE;
wire wr_go = acc & PREADY & PWRITE & ~PSLVERR;
wire slow_rise = slow_s2 & ~slow_s3;
wire bod_flag = bod_s2;
wire direct_on = bod_ctrl[`LPB_BOD_DIRECT_SRC] ? FIB_DIRECT_RST_EN :
    bod_ctrl[`LPB_BOD_DIRECT_EN];
wire count_on = bod_ctrl[`LPB_BOD_COUNT_EN] & ~direct_on;
wire stall_ok = (stall_cnt >= STALL_LIM);
wire alarm_hit = ctrl[`LPB_CTRL_TIMER_WAKE] & (timer >= alarm);
wire woke = WAKE_REQ | alarm_hit;

// next power mode
reg [1:0] next_mode;
reg [1:0] next_target;
always @*
begin
    next_mode = mode;
    next_target = target;
    case (mode)
        ST_ACTIVE, ST_MODEM:
        begin
            if (!is_sleep(target))
                next_mode = target;
            else if (stall_ok)
                next_mode = target;
        end
        ST_LIGHT, ST_DEEP:
        begin
            if (woke)
            begin
                next_mode = ST_MODEM;
                next_target = ST_MODEM;
            end
        end
        default:
            next_mode = ST_MODEM;
    endcase
end

wire pd_entry = ~is_sleep(mode) & is_sleep(next_mode);
wire xtal_next = ~is_sleep(next_mode);
wire xtal_up = xtal_next & ~xtal_d;
wire stall_edge = CPU_STALL ^ stall_d;
wire cap = (ctrl[`LPB_CTRL_CAP_XTAL] & (pd_entry | xtal_up)) |
    (ctrl[`LPB_CTRL_CAP_STALL] & stall_edge) |
    (ctrl[`LPB_CTRL_CAP_RST] & SYS_RST_DONE) |
    sw_snap;

// read mux
reg [31:0] rd;
reg rd_err;
always @*
begin
    rd = 32'h0;
    rd_err = 1'b0;
    if (PADDR == `LPB_OFS_CTRL)
        rd[`LPB_CTRL_W-1:0] = ctrl;
    else if (PADDR == `LPB_OFS_SNAP_REQ)
        rd = 32'h0;
    else if (PADDR == `LPB_OFS_CUR_LOW)
        rd = snap_cur[31:0];
    else if (PADDR == `LPB_OFS_CUR_HIGH)
        rd[15:0] = snap_cur[47:32];
    else if (PADDR == `LPB_OFS_PREV_LOW)
        rd = snap_prev[31:0];
    else if (PADDR == `LPB_OFS_PREV_HIGH)
        rd[15:0] = snap_prev[47:32];
    else if (PADDR == `LPB_OFS_TIME_LOW)
        rd = timer[31:0];
    else if (PADDR == `LPB_OFS_TIME_HIGH)
        rd[15:0] = timer[47:32];
    else if (PADDR == `LPB_OFS_BOD_CTRL)
        rd[`LPB_BOD_W-1:0] = bod_ctrl;
    else if (PADDR == `LPB_OFS_BOD_IRQ_WAIT)
        rd[BOD_CNT_W-1:0] = bod_irq_wait;
    else if (PADDR == `LPB_OFS_BOD_RST_WAIT)
        rd[BOD_CNT_W-1:0] = bod_rst_wait;
    else if (PADDR == `LPB_OFS_BOD_STATUS)
    begin
        rd[0] = bod_flag;
        rd[1] = BROWNOUT_IRQ;
        rd[31:16] = bod_cnt[15:0];
    end
    else if (PADDR == `LPB_OFS_PMODE)
    begin
        rd[1:0] = mode;
        rd[3:2] = target;
    end
    else if (PADDR == `LPB_OFS_ALARM_LOW)
        rd = alarm[31:0];
    else if (PADDR == `LPB_OFS_ALARM_HIGH)
        rd[15:0] = alarm[47:32];
    else
        rd_err = 1'b1;
end

// synchronisers, never gated by mode; they advance only while CE is high
always @(posedge CLK_SYS)
begin
    if (RST)
    begin
        slow_s1 <= 1'b0;
        slow_s2 <= 1'b0;
        slow_s3 <= 1'b0;
        bod_s1 <= 1'b0;
        bod_s2 <= 1'b0;
        cen_s1 <= 1'b0;
        cen_s2 <= 1'b0;
    end
    else if (CE)
    begin
        slow_s1 <= LP_SLOW_CLK;
        slow_s2 <= slow_s1;
        slow_s3 <= slow_s2;
        bod_s1 <= BROWNOUT_DET;
        bod_s2 <= bod_s1;
        cen_s1 <= CHIP_EN;
        cen_s2 <= cen_s1;
    end
end

// apb slave, one wait state
always @(posedge CLK_SYS)
begin
    if (RST)
    begin
        PREADY <= 1'b0;
        PRDATA <= 32'h0;
        PSLVERR <= 1'b0;
        ctrl <= `LPB_CTRL_RESET;
        bod_ctrl <= `LPB_BOD_RESET;
        bod_irq_wait <= {BOD_CNT_W{1'b1}};
        bod_rst_wait <= {BOD_CNT_W{1'b1}};
        alarm <= 48'hffffffffffff;
        sw_snap <= 1'b0;
    end
    else if (CE)
    begin
        sw_snap <= 1'b0;
        if (acc & ~PREADY)
        begin
            PREADY <= 1'b1;
            PRDATA <= rd;
            PSLVERR <= rd_err;
        end
        else
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        if (wr_go)
        begin
            if (PADDR == `LPB_OFS_CTRL)
                ctrl <= PWDATA[`LPB_CTRL_W-1:0];
            else if (PADDR == `LPB_OFS_SNAP_REQ)
                sw_snap <= PWDATA[0];
            else if (PADDR == `LPB_OFS_BOD_CTRL)
                bod_ctrl <= PWDATA[`LPB_BOD_W-1:0];
            else if (PADDR == `LPB_OFS_BOD_IRQ_WAIT)
                bod_irq_wait <= PWDATA[BOD_CNT_W-1:0];
            else if (PADDR == `LPB_OFS_BOD_RST_WAIT)
                bod_rst_wait <= PWDATA[BOD_CNT_W-1:0];
            else if (PADDR == `LPB_OFS_ALARM_LOW)
                alarm[31:0] <= PWDATA;
            else if (PADDR == `LPB_OFS_ALARM_HIGH)
                alarm[47:32] <= PWDATA[15:0];
        end
    end
end

// timer and snapshots; RST is the power-up reset
always @(posedge CLK_SYS)
begin
    if (RST)
    begin
        timer <= 48'h0;
        snap_cur <= 48'h0;
        snap_prev <= 48'h0;
        stall_d <= 1'b0;
        xtal_d <= 1'b1;
    end
    else if (CE)
    begin
        if (slow_rise)
            timer <= timer + 48'h1;
        stall_d <= CPU_STALL;
        xtal_d <= xtal_next;
        if (cap)
        begin
            snap_prev <= snap_cur;
            snap_cur <= timer;
        end
    end
end

// brownout handling
always @(posedge CLK_SYS)
begin
    if (RST)
    begin
        bod_cnt <= {BOD_CNT_W{1'b0}};
        BROWNOUT_IRQ <= 1'b0;
        RADIO_SHUTDOWN <= 1'b0;
        CHIP_RESET_REQ <= 1'b0;
        SYS_RESET_REQ <= 1'b0;
    end
    else if (CE)
    begin
        if (!bod_flag || !count_on)
            bod_cnt <= {BOD_CNT_W{1'b0}};
        else if (bod_cnt != {BOD_CNT_W{1'b1}})
            bod_cnt <= bod_cnt + 1'b1;
        RADIO_SHUTDOWN <= bod_flag;
        BROWNOUT_IRQ <= count_on & bod_flag &
            (bod_cnt >= bod_irq_wait);
        CHIP_RESET_REQ <= count_on & bod_flag &
            bod_ctrl[`LPB_BOD_CNT_RST_EN] &
            ~bod_ctrl[`LPB_BOD_RST_SCOPE] &
            (bod_cnt >= bod_rst_wait);
        SYS_RESET_REQ <= bod_flag & (direct_on |
            (count_on & bod_ctrl[`LPB_BOD_CNT_RST_EN] &
            bod_ctrl[`LPB_BOD_RST_SCOPE] &
            (bod_cnt >= bod_rst_wait)));
    end
end

// power mode machine and domain outputs
always @(posedge CLK_SYS)
begin
    if (RST)
    begin
        mode <= ST_MODEM;
        target <= ST_MODEM;
        stall_cnt <= 16'h0;
        TIMER_WAKEUP <= 1'b0;
        PD_RF_ON <= 1'b0;
        PD_FOSC_ON <= 1'b1;
        PD_XTAL_ON <= 1'b1;
        PD_PLL_ON <= 1'b1;
        PD_DIG_ON <= 1'b1;
        DIG_REG_PU <= 1'b1;
        LP_REG_ON <= 1'b1;
        LP_REG_DEEP <= 1'b0;
        POWER_MODE <= ST_MODEM;
    end
    else if (CE)
    begin
        if (!CPU_STALL)
            stall_cnt <= 16'h0;
        else if (!stall_ok)
            stall_cnt <= stall_cnt + 16'h1;
        mode <= next_mode;
        if (wr_go && PADDR == `LPB_OFS_PMODE)
            target <= PWDATA[1:0];
        else
            target <= next_target;
        TIMER_WAKEUP <= alarm_hit;
        POWER_MODE <= next_mode;
        PD_RF_ON <= (next_mode == ST_ACTIVE);
        PD_FOSC_ON <= ~is_sleep(next_mode);
        PD_XTAL_ON <= xtal_next;
        PD_PLL_ON <= xtal_next;
        PD_DIG_ON <= (next_mode != ST_DEEP);
        DIG_REG_PU <= ~(ctrl[`LPB_CTRL_WRAP_PD] &
            is_sleep(next_mode));
        LP_REG_ON <= 1'b1;
        LP_REG_DEEP <= cen_s2 & (next_mode == ST_DEEP);
    end
end

endmodule
`default_nettype wire

// file: logic/lpb_consts.vh
// constants for the low-power timer and brownout controller
// assumes a 32-bit apb slave with byte addresses on word boundaries
`ifndef LPB_CONSTS_VH
`define LPB_CONSTS_VH

// register byte offsets
`define LPB_OFS_CTRL 8'h00
`define LPB_OFS_SNAP_REQ 8'h04
`define LPB_OFS_CUR_LOW 8'h08
`define LPB_OFS_CUR_HIGH 8'h0c
`define LPB_OFS_PREV_LOW 8'h10
`define LPB_OFS_PREV_HIGH 8'h14
`define LPB_OFS_TIME_LOW 8'h18
`define LPB_OFS_TIME_HIGH 8'h1c
`define LPB_OFS_BOD_CTRL 8'h20
`define LPB_OFS_BOD_IRQ_WAIT 8'h24
`define LPB_OFS_BOD_RST_WAIT 8'h28
`define LPB_OFS_BOD_STATUS 8'h2c
`define LPB_OFS_PMODE 8'h30
`define LPB_OFS_ALARM_LOW 8'h34
`define LPB_OFS_ALARM_HIGH 8'h38

// control register fields
`define LPB_CTRL_CAP_XTAL 0
`define LPB_CTRL_CAP_STALL 1
`define LPB_CTRL_CAP_RST 2
`define LPB_CTRL_WRAP_PD 3
`define LPB_CTRL_TIMER_WAKE 4
`define LPB_CTRL_W 5
`define LPB_CTRL_RESET 5'h00

// brownout control fields
`define LPB_BOD_COUNT_EN 0
`define LPB_BOD_CNT_RST_EN 1
`define LPB_BOD_RST_SCOPE 2
`define LPB_BOD_DIRECT_EN 3
`define LPB_BOD_DIRECT_SRC 4
`define LPB_BOD_W 5
`define LPB_BOD_RESET 5'h00

// power modes
`define LPB_MODE_ACTIVE 2'h0
`define LPB_MODE_MODEM 2'h1
`define LPB_MODE_LIGHT 2'h2
`define LPB_MODE_DEEP 2'h3

// timing: cpu stall time before sleep entry
`define LPB_CLK_MHZ 100
`define LPB_STALL_WAIT_NS 1000
`define LPB_STALL_WAIT_CYC (`LPB_STALL_WAIT_NS * `LPB_CLK_MHZ / 1000)

`endif

// file: dv/lpb_ctrl_props.sv
// checker for the low-power timer, brownout and power-mode block
// assumes it is bound to lpb_ctrl and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module lpb_ctrl_props (
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire BROWNOUT_DET,
    input wire CPU_STALL,
    input wire BROWNOUT_IRQ,
    input wire RADIO_SHUTDOWN,
    input wire CHIP_RESET_REQ,
    input wire SYS_RESET_REQ,
    input wire PD_RF_ON,
    input wire PD_XTAL_ON,
    input wire PD_DIG_ON,
    input wire DIG_REG_PU,
    input wire [1:0] POWER_MODE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    a_apb_answer: assert property (PSEL && PENABLE && !PREADY && CE |=> PREADY)
        else $error("no apb answer");
    a_ready_pulse: assert property (PREADY && CE |=> !PREADY)
        else $error("ready held too long");
    a_radio_follow: assert property ($rose(BROWNOUT_DET) |-> ##[1:4] RADIO_SHUTDOWN)
        else $error("radio not shut down");
    a_active_on: assert property (POWER_MODE == 2'h0 |-> PD_RF_ON && PD_DIG_ON)
        else $error("active domains off");
    a_modem_rf: assert property (POWER_MODE == 2'h1 |-> !PD_RF_ON && PD_XTAL_ON)
        else $error("modem domains wrong");
    a_light_off: assert property (POWER_MODE == 2'h2 |-> !PD_XTAL_ON && PD_DIG_ON)
        else $error("light domains wrong");
    a_deep_off: assert property (POWER_MODE == 2'h3 |-> !PD_DIG_ON && !PD_RF_ON)
        else $error("deep domains wrong");
    a_sleep_stall: assert property ($past(POWER_MODE) < 2'h2 && POWER_MODE[1]
        |-> $past(CPU_STALL) && $past(CPU_STALL, 2))
        else $error("sleep without stall");
    a_dig_reg: assert property (!DIG_REG_PU |-> POWER_MODE[1])
        else $error("digital regulator off awake");
    a_irq_flag: assert property (BROWNOUT_IRQ || CHIP_RESET_REQ |-> RADIO_SHUTDOWN)
        else $error("brownout action without flag");
    a_one_scope: assert property (!(CHIP_RESET_REQ && SYS_RESET_REQ))
        else $error("both reset scopes");
    cover property (POWER_MODE == 2'h3);
    cover property (CHIP_RESET_REQ);
    cover property (SYS_RESET_REQ && !BROWNOUT_IRQ);
endmodule
bind lpb_ctrl lpb_ctrl_props lpb_ctrl_props_inst (.CLK_SYS, .RST, .CE,
    .PSEL, .PENABLE, .PREADY, .BROWNOUT_DET, .CPU_STALL, .BROWNOUT_IRQ,
    .RADIO_SHUTDOWN, .CHIP_RESET_REQ, .SYS_RESET_REQ, .PD_RF_ON,
    .PD_XTAL_ON, .PD_DIG_ON, .DIG_REG_PU, .POWER_MODE);
`default_nettype wire

// file: dv/tb_lpb_ctrl.sv
// self-checking bench for the low-power timer and brownout block
// assumes lpb_ctrl with a short stall wait and one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "lpb_consts.vh"
module tb_lpb_ctrl;
    logic CLK_SYS = 0;
    logic RST = 1;
    logic PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic LP_SLOW_CLK = 0, BROWNOUT_DET = 0, CPU_STALL = 0;
    logic SYS_RST_DONE = 0, WAKE_REQ = 0, FIB_DIRECT_RST_EN = 0;
    logic CE = 1, CHIP_EN = 1;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, BROWNOUT_IRQ, RADIO_SHUTDOWN, CHIP_RESET_REQ;
    wire SYS_RESET_REQ, TIMER_WAKEUP, PD_RF_ON, PD_FOSC_ON, PD_XTAL_ON;
    wire PD_PLL_ON, PD_DIG_ON, DIG_REG_PU, LP_REG_ON, LP_REG_DEEP;
    wire [1:0] POWER_MODE;
    int n_fail = 0, num_checks = 0, cyc = 0, k, w, i;
    logic [47:0] t0, t1;
    logic [31:0] q;
    logic e;
    lpb_ctrl #(.STALL_WAIT(4)) lpb_ctrl_inst (.CLK_SYS, .RST, .CE,
        .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .LP_SLOW_CLK, .BROWNOUT_DET, .CHIP_EN, .CPU_STALL,
        .SYS_RST_DONE, .WAKE_REQ, .FIB_DIRECT_RST_EN, .BROWNOUT_IRQ,
        .RADIO_SHUTDOWN, .CHIP_RESET_REQ, .SYS_RESET_REQ, .TIMER_WAKEUP,
        .PD_RF_ON, .PD_FOSC_ON, .PD_XTAL_ON, .PD_PLL_ON, .PD_DIG_ON,
        .DIG_REG_PU, .LP_REG_ON, .LP_REG_DEEP, .POWER_MODE);
    always #5 CLK_SYS = ~CLK_SYS;
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge CLK_SYS)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1;
        do
        begin
            @(posedge CLK_SYS);
        end
        while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task rd48(input logic [7:0] a, output logic [47:0] v);
        apb(0, a, 0);
        v[31:0] = q;
        apb(0, a + 8'h04, 0);
        v[47:32] = q[15:0];
    endtask
    task slow(input int n);
        repeat (n)
        begin
            @(posedge CLK_SYS);
            LP_SLOW_CLK <= 1;
            repeat (3) @(posedge CLK_SYS);
            LP_SLOW_CLK <= 0;
            repeat (3) @(posedge CLK_SYS);
        end
        repeat (6) @(posedge CLK_SYS);
    endtask
    task tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    initial
    begin
        k = $urandom(32'h84b48e9c);
        tick(6);
        RST <= 0;
        tick(1);
        chk(POWER_MODE, 2'h1);
        chk({PD_RF_ON, PD_DIG_ON, LP_REG_ON, RADIO_SHUTDOWN}, 4'h6);
        $display("test reset done");
        k = 1 + $urandom % 6;
        rd48(`LPB_OFS_TIME_LOW, t0);
        apb(1, `LPB_OFS_SNAP_REQ, 32'h1);
        slow(k);
        rd48(`LPB_OFS_TIME_LOW, t1);
        chk(t1 - t0, k);
        CE <= 0;
        slow(2);
        CE <= 1;
        rd48(`LPB_OFS_TIME_LOW, t1);
        chk(t1, t0 + k);
        apb(1, `LPB_OFS_SNAP_REQ, 32'h1);
        rd48(`LPB_OFS_CUR_LOW, t1);
        chk(t1, t0 + k);
        rd48(`LPB_OFS_PREV_LOW, t1);
        chk(t1, t0);
        $display("test timer done");
        for (i = 0; i < 3; i++)
        begin
            apb(1, `LPB_OFS_CTRL, 32'h1 << i);
            slow(1);
            rd48(`LPB_OFS_TIME_LOW, t0);
            if (i == 0)
                apb(1, `LPB_OFS_PMODE, 32'h2);
            SYS_RST_DONE <= (i == 2);
            tick(1);
            SYS_RST_DONE <= 0;
            CPU_STALL <= 1;
            tick(10);
            chk(PD_XTAL_ON, i != 0);
            rd48(`LPB_OFS_CUR_LOW, t1);
            chk(t1, t0);
            CPU_STALL <= 0;
            WAKE_REQ <= 1;
            tick(1);
            WAKE_REQ <= 0;
            apb(1, `LPB_OFS_PMODE, 32'h1);
        end
        chk(POWER_MODE, 2'h1);
        rd48(`LPB_OFS_TIME_LOW, t0);
        apb(1, `LPB_OFS_ALARM_HIGH, {16'h0, t0[47:32]});
        apb(1, `LPB_OFS_ALARM_LOW, t0[31:0] + 32'h2);
        apb(1, `LPB_OFS_CTRL, 32'h10);
        tick(2);
        chk(TIMER_WAKEUP, 1'b0);
        slow(2);
        chk(TIMER_WAKEUP, 1'b1);
        $display("test capture done");
        apb(1, `LPB_OFS_CTRL, 32'h8);
        apb(1, `LPB_OFS_PMODE, 32'h3);
        tick(8);
        chk(POWER_MODE, 2'h1);
        CPU_STALL <= 1;
        tick(8);
        chk({POWER_MODE, PD_DIG_ON, DIG_REG_PU, LP_REG_ON}, 5'h19);
        chk({LP_REG_ON, LP_REG_DEEP}, 2'h3);
        chk({PD_FOSC_ON, PD_PLL_ON}, 2'h0);
        CPU_STALL <= 0;
        WAKE_REQ <= 1;
        tick(2);
        WAKE_REQ <= 0;
        apb(1, `LPB_OFS_PMODE, 32'h0);
        tick(2);
        chk({POWER_MODE, PD_RF_ON, DIG_REG_PU}, 4'h3);
        $display("test modes done");
        for (i = 0; i < 2; i++)
        begin
            w = 2 + $urandom % 8;
            apb(1, `LPB_OFS_BOD_IRQ_WAIT, w);
            apb(1, `LPB_OFS_BOD_RST_WAIT, w + 3);
            apb(1, `LPB_OFS_BOD_CTRL, 32'h3 | (i << 2));
            BROWNOUT_DET <= 1;
            for (k = 0; BROWNOUT_IRQ !== 1'b1 && k < 40; k++)
                tick(1);
            chk(k, w + 4);
            for (k = 0; (i ? SYS_RESET_REQ : CHIP_RESET_REQ) !== 1'b1
                && k < 9; k++)
                tick(1);
            chk(k, 3);
            apb(0, `LPB_OFS_BOD_STATUS, 0);
            chk(q[1:0], 2'h3);
            BROWNOUT_DET <= 0;
            tick(6);
            apb(0, `LPB_OFS_BOD_STATUS, 0);
            chk({q, CHIP_RESET_REQ, SYS_RESET_REQ}, 0);
        end
        for (i = 0; i < 2; i++)
        begin
            apb(1, `LPB_OFS_BOD_CTRL, i ? 32'h11 : 32'h9);
            FIB_DIRECT_RST_EN <= i[0];
            BROWNOUT_DET <= 1;
            tick(5);
            chk({SYS_RESET_REQ, BROWNOUT_IRQ}, 2'h2);
            BROWNOUT_DET <= 0;
            tick(6);
        end
        $display("test brownout done");
        apb(0, 8'hfc, 0);
        chk({e, q}, 33'h100000000);
        apb(1, 8'hfc, 32'hffffffff);
        chk(e, 1'b1);
        $display("test unmapped done");
        complete_run();
    end
endmodule
`default_nettype wire
